// ---- bp_pkg.sv ----
// Package with the layout and reset values of the breakpoint status and control registers.
package bp_pkg;
	localparam int NUM_CMP = 4;
	localparam int STAT_HIT_LSB = 0;
	localparam int STAT_REG_ACCESS_BIT = 13;
	localparam int STAT_STEP_BIT = 14;
	localparam int STAT_TASK_BIT = 15;
	localparam logic [31:0] STAT_ONES_MASK = 32'hFFFF_0FF0;
	localparam logic [31:0] STAT_RW_MASK = 32'h0000_E00F;
	localparam logic [31:0] STAT_RESET = 32'hFFFF_0FF0;
	localparam int CTL_DETECT_BIT = 13;
	localparam int CTL_LOCAL_PRECISE_BIT = 8;
	localparam int CTL_GLOBAL_PRECISE_BIT = 9;
	localparam int CTL_TYPE_LSB = 16;
	localparam int CTL_RANGE_LSB = 18;
	localparam int CTL_FIELD_STRIDE = 4;
	localparam logic [31:0] CTL_RW_MASK = 32'hFFFF_23FF;
	localparam logic [31:0] CTL_ONES_MASK = 32'h0000_0400;
	localparam logic [31:0] CTL_RESET = 32'h0000_0400;
	localparam logic [31:0] LOCAL_EN_MASK = 32'h0000_0055;
	localparam logic [1:0] TYPE_EXEC = 2'h0;
	localparam logic [1:0] TYPE_WRITE = 2'h1;
	localparam logic [1:0] TYPE_IO = 2'h2;
	localparam logic [1:0] TYPE_RDWR = 2'h3;
	localparam logic [1:0] RANGE_1 = 2'h0;
	localparam logic [1:0] RANGE_2 = 2'h1;
	localparam logic [1:0] RANGE_8 = 2'h2;
	localparam logic [1:0] RANGE_4 = 2'h3;
	localparam logic [2:0] SEL_STATUS = 3'h6;
	localparam logic [2:0] SEL_CONTROL = 3'h7;
	typedef struct packed {
		logic valid;
		logic exec;
		logic wr;
		logic rd;
		logic io;
		logic [2:0] addr_lo;
	} access_t;
	typedef struct packed {
		logic bp_event;
		logic step;
		logic task_trap;
		logic task_switch;
		logic handler_entry;
	} event_t;
endpackage

// ---- cmp_qualify.sv ----
// Per-comparator qualification of a raw address match by type, range and enables.
`timescale 1ns/100ps
module cmp_qualify (
	input wire logic [31:0] control_i,
	input wire logic [bp_pkg::NUM_CMP-1:0] raw_match_i,
	input wire logic [2:0] raw_addr_hi_i [bp_pkg::NUM_CMP],
	input wire bp_pkg::access_t acc_i,
	input wire logic io_ext_i,
	input wire logic long_mode_i,
	output logic [bp_pkg::NUM_CMP-1:0] hit_o
);
	genvar g;
	generate
		for (g = 0; g < bp_pkg::NUM_CMP; g++) begin : g_cmp
			wire [1:0] typ = control_i[bp_pkg::CTL_TYPE_LSB + g*bp_pkg::CTL_FIELD_STRIDE +: 2];
			wire [1:0] rng = control_i[bp_pkg::CTL_RANGE_LSB + g*bp_pkg::CTL_FIELD_STRIDE +: 2];
			wire en = control_i[2*g] | control_i[2*g+1];
			// Type selects which kind of access may trigger; I/O only with the extension bit. [RQ12]
			wire type_ok = (typ == bp_pkg::TYPE_EXEC) ? acc_i.exec :
				(typ == bp_pkg::TYPE_WRITE) ? acc_i.wr :
				(typ == bp_pkg::TYPE_RDWR) ? (acc_i.rd | acc_i.wr) : (io_ext_i & acc_i.io);
			// Range masks the low address bits; eight bytes exists only in long mode. [RQ13]
			wire [2:0] mask = (rng == bp_pkg::RANGE_1) ? 3'h7 :
				(rng == bp_pkg::RANGE_2) ? 3'h6 :
				(rng == bp_pkg::RANGE_4) ? 3'h4 : (long_mode_i ? 3'h0 : 3'h7);
			wire addr_ok = ((acc_i.addr_lo & mask) == (raw_addr_hi_i[g] & mask));
			assign hit_o[g] = acc_i.valid & raw_match_i[g] & en & type_ok & addr_ok;
		end
	endgenerate
endmodule

// ---- breakpoint_status_control.sv ----
// Breakpoint status and control register pair with hardware event updates.
`timescale 1ns/100ps
// Operation
// RQ1 - Task-switch, single-step and register-access flags clear only by software write.
// RQ2 - Every breakpoint or general-detect event rewrites all four hit flags.
// RQ3 - Register access while general detect is on sets status bit 13.
// RQ4 - Single-step debug exception sets status bit 14.
// RQ5 - Single step has top priority; other flags may set alongside it.
// RQ6 - Switch into a trapped task sets status bit 15.
// RQ7 - Status bits 31-16 and 11-4 read one, bit 12 reads zero.
// RQ8 - Upper status or control half written with ones raises protection fault zero.
// RQ9 - Control holds per-comparator conditions, enables and a general-detect enable.
// RQ10 - Global enables at odd control bits 7, 5, 3, 1.
// RQ11 - Local enables at even control bits 6, 4, 2, 0.
// RQ12 - Access type selects execute, write, read-write or I/O trigger.
// RQ13 - Range field masks low address bits; software aligns addresses.
// RQ14 - General detect faults before the move, sets flag, clears on handler entry.
// RQ15 - Hardware task switch clears local enables, never the global ones.
// RQ16 - Writable fields store written values; reserved bits read fixed values.
module breakpoint_status_control (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [2:0] sel_i,
	input wire logic [63:0] wdata_i,
	input wire logic mode64_i,
	input wire logic long_mode_i,
	input wire logic io_ext_i,
	input wire bp_pkg::event_t evt_i,
	input wire bp_pkg::access_t acc_i,
	input wire logic [bp_pkg::NUM_CMP-1:0] raw_match_i,
	input wire logic [2:0] raw_addr_lo_i [bp_pkg::NUM_CMP],
	output logic [63:0] rdata_o,
	output logic fault_o,
	output logic detect_trap_o,
	output logic [31:0] control_o
);
	logic [31:0] status_ff;
	logic [31:0] control_ff;
	logic [63:0] rdata_ff;
	logic fault_ff;
	logic detect_trap_ff;
	logic [bp_pkg::NUM_CMP-1:0] hit;

	// ----------------------------------------
	// Comparator qualification
	// ----------------------------------------
	cmp_qualify u_cmp (
		.control_i(control_ff),
		.raw_match_i(raw_match_i),
		.raw_addr_hi_i(raw_addr_lo_i),
		.acc_i(acc_i),
		.io_ext_i(io_ext_i),
		.long_mode_i(long_mode_i),
		.hit_o(hit)
	);

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	wire sel_status = (sel_i == bp_pkg::SEL_STATUS);
	wire sel_control = (sel_i == bp_pkg::SEL_CONTROL);
	wire detect_on = control_ff[bp_pkg::CTL_DETECT_BIT];
	wire any_access = wr_i | rd_i;
	// Any debug register move is trapped before it executes while general detect is on. [RQ14]
	wire detect_trap = any_access & detect_on;
	wire upper_bad = mode64_i & (wdata_i[63:32] != 32'h0000_0000);
	wire wr_ok = wr_i & ~detect_trap & ~upper_bad;
	// A refused upper-half write leaves both registers untouched and only raises the fault. [RQ8]
	wire wr_fault = wr_i & ~detect_trap & upper_bad & (sel_status | sel_control);
	wire wr_stat = wr_ok & sel_status;
	wire wr_ctl = wr_ok & sel_control;
	wire rd_ok = rd_i & ~detect_trap;
	wire hit_update = evt_i.bp_event | detect_trap;

	// ----------------------------------------
	// Status next value
	// ----------------------------------------
	wire [31:0] stat_kept = status_ff & bp_pkg::STAT_RW_MASK;
	wire [31:0] stat_written = wdata_i[31:0] & bp_pkg::STAT_RW_MASK;
	wire [31:0] stat_sw = wr_stat ? stat_written : stat_kept; // [RQ16]
	wire [31:0] stat_hits = hit_update ? {stat_sw[31:4], hit} : stat_sw; // [RQ2]
	// Hardware events only ever set these flags; a same-cycle set beats the software clear. [RQ1]
	wire [31:0] stat_flags = stat_hits
		| ({31'h0000_0000, detect_trap} << bp_pkg::STAT_REG_ACCESS_BIT) // [RQ3]
		| ({31'h0000_0000, evt_i.step} << bp_pkg::STAT_STEP_BIT) // [RQ4] [RQ5]
		| ({31'h0000_0000, evt_i.task_trap} << bp_pkg::STAT_TASK_BIT); // [RQ6]
	wire [31:0] nxt_status = stat_flags | bp_pkg::STAT_ONES_MASK; // [RQ7]

	// ----------------------------------------
	// Control next value
	// ----------------------------------------
	wire [31:0] ctl_written = (wdata_i[31:0] & bp_pkg::CTL_RW_MASK) | bp_pkg::CTL_ONES_MASK;
	wire [31:0] ctl_sw = wr_ctl ? ctl_written : control_ff; // [RQ9] [RQ16]
	wire [31:0] ctl_ts = evt_i.task_switch ? (ctl_sw & ~bp_pkg::LOCAL_EN_MASK) : ctl_sw; // [RQ15] [RQ10] [RQ11]
	// Handler entry wins over a same-cycle write so the handler can always reach the registers.
	wire [31:0] detect_clear_mask = ~(32'h0000_0001 << bp_pkg::CTL_DETECT_BIT);
	wire [31:0] nxt_control = evt_i.handler_entry ? (ctl_ts & detect_clear_mask) : ctl_ts; // [RQ14]

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Only the low half is stored, so the upper half of read data is always zero.
	wire [63:0] nxt_rdata = (rd_ok & sel_status) ? {32'h0000_0000, status_ff} :
		(rd_ok & sel_control) ? {32'h0000_0000, control_ff} : 64'h0000_0000_0000_0000;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			status_ff <= bp_pkg::STAT_RESET;
			control_ff <= bp_pkg::CTL_RESET;
			rdata_ff <= 64'h0000_0000_0000_0000;
			fault_ff <= 1'b0;
			detect_trap_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			control_ff <= nxt_control;
			rdata_ff <= nxt_rdata;
			fault_ff <= wr_fault; // [RQ8]
			detect_trap_ff <= detect_trap;
		end
	end

	assign rdata_o = rdata_ff;
	assign fault_o = fault_ff;
	assign detect_trap_o = detect_trap_ff;
	assign control_o = control_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_detect_access;
		any_access && detect_on;
	endsequence

	sequence s_bad_upper_write;
		wr_i && !detect_on && upper_bad && sel_status;
	endsequence

	sequence s_handler_entry;
		evt_i.handler_entry;
	endsequence

	a_reserved_status: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ7]
		(status_ff & 32'hFFFF_1FF0) == bp_pkg::STAT_ONES_MASK)
		else $error("status reserved bits wrong");

	a_reserved_control: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ16]
		(control_ff & ~bp_pkg::CTL_RW_MASK) == bp_pkg::CTL_ONES_MASK)
		else $error("control reserved bits wrong");

	a_detect_sets_flag: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ3]
		s_detect_access |=> status_ff[bp_pkg::STAT_REG_ACCESS_BIT] && detect_trap_o)
		else $error("general detect flag not set");

	a_detect_blocks_write: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ14]
		s_detect_access and (wr_i && sel_control) |=> control_ff[13:0] == $past(control_ff[13:0])
		|| $past(evt_i.handler_entry) || $past(evt_i.task_switch))
		else $error("trapped move executed");

	a_detect_refused_read: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ14]
		s_detect_access |=> rdata_o == 64'h0000_0000_0000_0000)
		else $error("trapped read returned data");

	a_detect_clears: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ14]
		s_handler_entry |=> !control_ff[bp_pkg::CTL_DETECT_BIT])
		else $error("general detect not cleared on handler entry");

	a_step_sets: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ4]
		evt_i.step |=> status_ff[bp_pkg::STAT_STEP_BIT])
		else $error("single step flag not set");

	a_task_sets: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ6]
		evt_i.task_trap |=> status_ff[bp_pkg::STAT_TASK_BIT])
		else $error("task flag not set");

	a_flags_sticky: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ1]
		$past(status_ff[15]) && !$past(wr_stat) |-> status_ff[15])
		else $error("task flag cleared by hardware");

	a_hits_rewrite: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ2]
		evt_i.bp_event |=> status_ff[3:0] == $past(hit))
		else $error("hit flags not rewritten");

	a_upper_fault: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ8]
		s_bad_upper_write |=> fault_o && status_ff == $past(status_ff)
		|| $past(evt_i.bp_event | evt_i.step | evt_i.task_trap) && fault_o)
		else $error("upper half fault missing");

	a_no_fault_clean: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ8]
		!(wr_i && upper_bad) |=> !fault_o)
		else $error("fault raised without bad write");

	a_task_clears: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ15]
		evt_i.task_switch && !wr_ctl |=> (control_ff & bp_pkg::LOCAL_EN_MASK) == 32'h0000_0000)
		else $error("local enables not cleared");

	a_global_kept: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ15]
		evt_i.task_switch && !wr_ctl |=> (control_ff[7:0] & 8'hAA) == ($past(control_ff[7:0]) & 8'hAA))
		else $error("global enables changed by task switch");

	a_control_stores: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ16]
		wr_i && !detect_on && !upper_bad && sel_control && !evt_i.task_switch && !evt_i.handler_entry
		|=> control_ff == (($past(wdata_i[31:0]) & bp_pkg::CTL_RW_MASK) | bp_pkg::CTL_ONES_MASK))
		else $error("control write not stored");

	a_status_readback: assert property (@(posedge clock_i) disable iff (!rstn_i) // [RQ16]
		rd_i && !detect_on && sel_status |=> rdata_o == {32'h0000_0000, $past(status_ff)})
		else $error("status read data wrong");
endmodule

// ---- exec_model.sv ----
// Partner model of the execution logic, turning bench command codes into event pulses.
`timescale 1ns/100ps
module exec_model (
	input wire logic [2:0] cmd_i,
	output bp_pkg::event_t evt_o
);
	assign evt_o.bp_event = (cmd_i == 3'h1);
	assign evt_o.step = (cmd_i == 3'h2);
	assign evt_o.task_trap = (cmd_i == 3'h3);
	assign evt_o.task_switch = (cmd_i == 3'h4);
	assign evt_o.handler_entry = (cmd_i == 3'h5);
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the breakpoint status and control registers.
`timescale 1ns/100ps
module tb_top;
	typedef struct {logic [2:0] sel; logic [63:0] wdata; logic [63:0] exp;} row_t;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic mode64_i = 1'b0;
	logic [2:0] sel_i = 3'h0;
	logic [2:0] cmd = 3'h0;
	logic [63:0] wdata_i = 64'h0;
	logic [3:0] raw_match_i = 4'h0;
	logic [2:0] raw_addr_lo_i [bp_pkg::NUM_CMP] = '{default: 3'h0};
	bp_pkg::access_t acc_i = '0;
	bp_pkg::event_t evt_i;
	logic [63:0] rdata_o;
	logic fault_o;
	logic detect_trap_o;
	logic io_ext_i = 1'b0;
	logic long_mode_i = 1'b0;
	logic [31:0] control_o;
	logic flt;
	logic trp;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	row_t rows [5] = '{'{3'h7, 64'hFFFF_DFFF, 64'h0000_0000_FFFF_07FF}, '{3'h7, 64'h0, 64'h0000_0000_0000_0400},
		'{3'h6, 64'hFFFF_FFFF, 64'h0000_0000_FFFF_EFFF}, '{3'h6, 64'h0, 64'h0000_0000_FFFF_0FF0},
		'{3'h3, 64'h5, 64'h0}};
	exec_model partner (.cmd_i(cmd), .evt_o(evt_i));
	breakpoint_status_control uut (.clock_i(clock_i), .rstn_i(rstn_i), .wr_i(wr_i), .rd_i(rd_i), .sel_i(sel_i),
		.wdata_i(wdata_i), .mode64_i(mode64_i), .long_mode_i(long_mode_i), .io_ext_i(io_ext_i), .evt_i(evt_i),
		.acc_i(acc_i), .raw_match_i(raw_match_i), .raw_addr_lo_i(raw_addr_lo_i), .rdata_o(rdata_o),
		.fault_o(fault_o), .detect_trap_o(detect_trap_o), .control_o(control_o));
	initial begin
		forever #50 clock_i = ~clock_i;
	end
	task automatic give_verdict;
		if (mismatches == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [2:0] sel, input logic [63:0] data);
		@(negedge clock_i);
		wr_i = 1'b1;
		sel_i = sel;
		wdata_i = data;
		@(negedge clock_i);
		wr_i = 1'b0;
		flt = fault_o;
	endtask
	task automatic rd_reg(input logic [2:0] sel, output logic [63:0] data);
		@(negedge clock_i);
		rd_i = 1'b1;
		sel_i = sel;
		@(negedge clock_i);
		rd_i = 1'b0;
		data = rdata_o;
		trp = detect_trap_o;
	endtask
	task automatic pulse(input logic [2:0] code);
		@(negedge clock_i);
		cmd = code;
		@(negedge clock_i);
		cmd = 3'h0;
	endtask
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			give_verdict;
		end
	end
	initial begin
		logic [63:0] d;
		repeat (16) @(negedge clock_i);
		rstn_i = 1'b1;
		rd_reg(3'h6, d);
		chk("status_reset", d, 64'h0000_0000_FFFF_0FF0);
		rd_reg(3'h7, d);
		chk("control_reset", d, 64'h0000_0000_0000_0400);
		foreach (rows[i]) begin
			wr_reg(rows[i].sel, rows[i].wdata);
			rd_reg(rows[i].sel, d);
			chk("readback", d, rows[i].exp);
		end
		mode64_i = 1'b1;
		wr_reg(3'h7, 64'h0000_0001_0000_00FF);
		chk("fault", {63'h0, flt}, 64'h1);
		rd_reg(3'h7, d);
		chk("ignored_write", d, 64'h0000_0000_0000_0400);
		wr_reg(3'h7, 64'h0000_0000_0003_00FF);
		chk("control", {32'h0, control_o}, 64'h0000_0000_0003_04FF);
		raw_match_i = 4'h3;
		acc_i = '{valid: 1'b1, rd: 1'b1, default: '0};
		pulse(3'h1);
		raw_match_i = 4'h0;
		pulse(3'h2);
		pulse(3'h3);
		repeat (4) @(negedge clock_i);
		rd_reg(3'h6, d);
		chk("status_flags", d, 64'h0000_0000_FFFF_CFF1);
		pulse(3'h4);
		chk("local_clear", {32'h0, control_o}, 64'h0000_0000_0003_04AA);
		wr_reg(3'h6, 64'h0);
		rd_reg(3'h6, d);
		chk("status_clear", d, 64'h0000_0000_FFFF_0FF0);
		wr_reg(3'h7, 64'h0000_0000_0000_2000);
		rd_reg(3'h6, d);
		chk("detect_trap", {63'h0, trp}, 64'h1);
		chk("refused_read", d, 64'h0);
		pulse(3'h5);
		chk("detect_clear", {32'h0, control_o}, 64'h0000_0000_0000_0400);
		rd_reg(3'h6, d);
		chk("access_flag", d, 64'h0000_0000_FFFF_2FF0);
		io_ext_i = 1'b1;
		long_mode_i = 1'b1;
		wr_reg(3'h7, 64'h0000_0000_000A_0001);
		wr_reg(3'h6, 64'h0);
		raw_match_i = 4'h1;
		acc_i = '{valid: 1'b1, io: 1'b1, addr_lo: 3'h5, default: '0};
		pulse(3'h1);
		rd_reg(3'h6, d);
		chk("io_range_hit", d, 64'h0000_0000_FFFF_0FF1);
		long_mode_i = 1'b0;
		pulse(3'h1);
		rd_reg(3'h6, d);
		chk("range_no_long", d, 64'h0000_0000_FFFF_0FF0);
		give_verdict;
	end
endmodule
